// File: utb_tx_break.sv
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module utb_tx_break
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic             txd
);
   utb_pkg::utb_state_type s_r;
   utb_pkg::utb_state_type s_nxt;
   logic                   tick;
   logic                   wr;
   logic [31:0]            wd;
   logic [31:0]            wmask;
   logic [3:0]             flen;
   logic                   begin_c;
   logic                   end_c;
   logic                   start_acc;
   logic                   stop_acc;
   logic                   thr_wr;
   logic                   load;

   function automatic logic [31:0] be_mask(input logic [3:0] be);
      be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   function automatic logic [3:0] frame_len(input utb_pkg::utb_mode_type m);
      frame_len = utb_pkg::BASE_FRAME + {3'h0, m.even_par}
                  + {3'h0, m.two_stop};
   endfunction

   function automatic logic [31:0] rd_mux(input utb_pkg::utb_state_type s,
                                          input logic [7:0] a);
      rd_mux = 32'h0;
      case (a)
         utb_pkg::MODE_OFF:
         begin
            rd_mux[utb_pkg::PAR_BIT]   = s.mode.even_par;
            rd_mux[utb_pkg::STOP2_BIT] = s.mode.two_stop;
         end
         utb_pkg::CSR_OFF:
         begin
            rd_mux[utb_pkg::READY_BIT] = s.hold_free;
            rd_mux[utb_pkg::EMPTY_BIT] = s.all_empty;
         end
         utb_pkg::BAUD_OFF:
            rd_mux = {16'h0, s.baud_div};
         default:
            rd_mux = 32'h0;
      endcase
   endfunction

   // Bit period strobe from a down counter
   assign tick      = (s_r.baud_cnt == 16'h0);
   assign wr        = avs_write & ~s_r.waitreq;
   assign wmask     = be_mask(avs_byteenable);
   assign wd        = avs_writedata & wmask;
   assign flen      = frame_len(s_r.mode);
   assign begin_c   = wr & (avs_address == utb_pkg::CR_OFF)
                      & wd[utb_pkg::BEGIN_BIT];
   assign end_c     = wr & (avs_address == utb_pkg::CR_OFF)
                      & wd[utb_pkg::END_BIT];
   assign start_acc = begin_c & s_r.hold_free
                      & (s_r.brk == utb_pkg::ST_IDLE);
   assign stop_acc  = end_c & s_r.hold_free & ~s_r.stop_req
                      & (s_r.brk == utb_pkg::ST_BRK);
   assign thr_wr    = wr & (avs_address == utb_pkg::THR_OFF);
   // Shifter loads only outside a break
   assign load      = ~s_r.busy & s_r.hold_full
                      & (s_r.brk == utb_pkg::ST_IDLE);

   always_comb
   begin
      s_nxt = s_r;
      // Bus handshake: one wait cycle, then accept
      s_nxt.waitreq = ~((avs_read | avs_write) & s_r.waitreq);
      if (avs_read & s_r.waitreq)
         s_nxt.rdata = rd_mux(s_r, avs_address);
      if (wr & (avs_address == utb_pkg::MODE_OFF) & avs_byteenable[0])
      begin
         s_nxt.mode.even_par = wd[utb_pkg::PAR_BIT];
         s_nxt.mode.two_stop = wd[utb_pkg::STOP2_BIT];
      end
      if (wr & (avs_address == utb_pkg::BAUD_OFF))
         s_nxt.baud_div = (s_r.baud_div & ~wmask[15:0]) | wd[15:0];

      if (tick)
         s_nxt.baud_cnt = (s_r.baud_div == 16'h0) ? 16'h0
                          : s_r.baud_div - 16'h1;
      else
         s_nxt.baud_cnt = s_r.baud_cnt - 16'h1;

      // Holding register write, dropped when not free
      if (thr_wr & s_r.hold_free)
      begin
         s_nxt.hold_data = wd[7:0];
         s_nxt.hold_full = 1'b1;
         s_nxt.hold_free = 1'b0;
      end

      if (start_acc)
      begin
         s_nxt.brk       = utb_pkg::ST_PEND;
         s_nxt.hold_free = 1'b0;
      end
      if (stop_acc)
      begin
         s_nxt.stop_req  = 1'b1;
         s_nxt.hold_free = 1'b0;
      end

      // Character shifter
      if (tick & s_r.busy)
      begin
         if (s_r.left != 4'h0)
         begin
            s_nxt.txd_sh = s_r.sh[0];
            s_nxt.sh     = {1'b1, s_r.sh[11:1]};
            s_nxt.left   = s_r.left - 4'h1;
         end
         else
         begin
            s_nxt.busy   = 1'b0;
            s_nxt.txd_sh = 1'b1;
         end
      end
      if (load)
      begin
         s_nxt.sh        = {2'b11,
                            s_r.mode.even_par ? ^s_r.hold_data : 1'b1,
                            s_r.hold_data, 1'b0};
         s_nxt.left      = flen;
         s_nxt.busy      = 1'b1;
         s_nxt.hold_full = 1'b0;
         s_nxt.hold_free = 1'b1;
      end

      // Break sequencer, paced by bit periods
      case (s_r.brk)
         utb_pkg::ST_IDLE:
            s_nxt.cnt = 4'h0;
         utb_pkg::ST_PEND:
            if (tick & ~s_r.busy)
            begin
               s_nxt.brk       = utb_pkg::ST_BRK;
               s_nxt.cnt       = 4'h0;
               s_nxt.hold_free = 1'b1;
            end
         utb_pkg::ST_BRK:
            if (tick)
            begin
               if (s_r.cnt < flen)
                  s_nxt.cnt = s_r.cnt + 4'h1;
               if (s_r.stop_req & (s_r.cnt >= flen - 4'h1))
               begin
                  s_nxt.brk      = utb_pkg::ST_POST;
                  s_nxt.cnt      = 4'h0;
                  s_nxt.stop_req = 1'b0;
               end
            end
         utb_pkg::ST_POST:
            if (tick)
            begin
               s_nxt.cnt = s_r.cnt + 4'h1;
               if (s_r.cnt >= utb_pkg::POST_IDLE - 4'h1)
               begin
                  s_nxt.brk       = utb_pkg::ST_IDLE;
                  s_nxt.cnt       = 4'h0;
                  s_nxt.hold_free = 1'b1;
               end
            end
         default:
            s_nxt.brk = utb_pkg::ST_IDLE;
      endcase

      // Line level
      if (s_nxt.brk == utb_pkg::ST_BRK)
         s_nxt.txd = 1'b0;
      else if (s_nxt.brk == utb_pkg::ST_POST)
         s_nxt.txd = 1'b1;
      else
         s_nxt.txd = s_nxt.txd_sh;

      s_nxt.all_empty = ~s_nxt.busy & ~s_nxt.hold_full
                        & ((s_nxt.brk == utb_pkg::ST_IDLE)
                           | (s_nxt.brk == utb_pkg::ST_PEND));
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
         s_r <= utb_pkg::STATE_RST;
      else
         s_r <= s_nxt;
   end

   assign avs_readdata    = s_r.rdata;
   assign avs_waitrequest = s_r.waitreq;
   assign txd             = s_r.txd;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   a_break_min_len: assert property (
      (s_r.brk == utb_pkg::ST_BRK) && (s_nxt.brk == utb_pkg::ST_POST)
      |-> (s_r.cnt >= flen - 4'h1) && s_r.stop_req && tick)
      else $error("Break ended before one character time");

   a_post_idle_len: assert property (
      (s_r.brk == utb_pkg::ST_POST) && (s_nxt.brk == utb_pkg::ST_IDLE)
      |-> (s_r.cnt == utb_pkg::POST_IDLE - 4'h1) && txd)
      else $error("Post-break idle shorter than twelve bit periods");

   a_break_waits_shift: assert property (
      (s_r.brk == utb_pkg::ST_PEND) && s_r.busy
      |=> (s_r.brk == utb_pkg::ST_PEND))
      else $error("Break started while shifter busy");

   a_ready_blocked: assert property (
      start_acc |=> !s_r.hold_free [*1] ##0 (s_r.brk == utb_pkg::ST_PEND))
      else $error("Holding-free not cleared by begin command");

   a_empty_in_break: assert property (
      (s_r.brk == utb_pkg::ST_BRK) |-> !s_r.all_empty && !txd)
      else $error("All-empty or line high during break");

   a_begin_ignored: assert property (
      begin_c && (s_r.brk != utb_pkg::ST_IDLE)
      |=> (s_r.brk != utb_pkg::ST_PEND)
          || ($past(s_r.brk) == utb_pkg::ST_PEND))
      else $error("Begin command acted during a break");

   a_end_ignored: assert property (
      end_c && (s_r.brk == utb_pkg::ST_IDLE) && !begin_c
      |=> (s_r.brk == utb_pkg::ST_IDLE) && !s_r.stop_req)
      else $error("End command acted without a break");

   a_discard_pending: assert property (
      thr_wr && (s_r.brk == utb_pkg::ST_PEND) && !s_r.hold_free
      |=> $stable(s_r.hold_data) && !s_r.hold_full)
      else $error("Holding write not discarded while break pending");

   a_ready_on_load: assert property (
      load |=> s_r.busy && s_r.hold_free && (s_r.left == $past(flen)))
      else $error("Holding-free not set on shifter load");

   a_shift_blocked: assert property (
      (s_r.brk != utb_pkg::ST_IDLE) && !s_r.busy |=> !s_r.busy)
      else $error("Shifter loaded during a break");

   a_bus_answer: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("Bus answer not one cycle after request");

   a_post_line_high: assert property (
      (s_r.brk == utb_pkg::ST_POST) |-> txd)
      else $error("Line low during post-break idle");

   a_free_after_break: assert property (
      (s_r.brk == utb_pkg::ST_POST) && (s_nxt.brk == utb_pkg::ST_IDLE)
      |=> s_r.hold_free && (s_r.brk == utb_pkg::ST_IDLE))
      else $error("Holding-free not restored after break");

   a_bus_one_wait: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("Wait request low for more than one cycle");

   c_break_done: cover property (
      (s_r.brk == utb_pkg::ST_POST) ##1 (s_r.brk == utb_pkg::ST_IDLE));
   c_break_after_char: cover property (
      (s_r.brk == utb_pkg::ST_PEND) && s_r.busy);
   c_char_sent: cover property (s_r.busy ##1 !s_r.busy);
   c_begin_ignored: cover property (begin_c && (s_r.brk == utb_pkg::ST_BRK));
   c_pending_discard: cover property (thr_wr && (s_r.brk == utb_pkg::ST_PEND));
endmodule
`default_nettype wire

// File: utb_pkg.sv
`default_nettype none
package utb_pkg;
   // Register byte offsets
   localparam logic [7:0]  CR_OFF      = 8'h00;
   localparam logic [7:0]  MODE_OFF    = 8'h04;
   localparam logic [7:0]  CSR_OFF     = 8'h14;
   localparam logic [7:0]  THR_OFF     = 8'h1c;
   localparam logic [7:0]  BAUD_OFF    = 8'h20;
   // Field positions
   localparam int          BEGIN_BIT   = 9;
   localparam int          END_BIT     = 10;
   localparam int          READY_BIT   = 1;
   localparam int          EMPTY_BIT   = 9;
   localparam int          PAR_BIT     = 0;
   localparam int          STOP2_BIT   = 1;
   // Timing in bit periods, reset baud divider in clocks per bit
   localparam logic [3:0]  BASE_FRAME  = 4'ha;
   localparam logic [3:0]  POST_IDLE   = 4'hc;
   localparam logic [15:0] BAUD_RST    = 16'h0010;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_PEND = 2'b01,
      ST_BRK  = 2'b10,
      ST_POST = 2'b11
   } utb_brk_type;

   typedef struct packed
   {
      logic even_par;
      logic two_stop;
   } utb_mode_type;

   localparam utb_mode_type MODE_RST = '{even_par: 1'b0, two_stop: 1'b0};

   typedef struct packed
   {
      logic         waitreq;
      logic [31:0]  rdata;
      utb_mode_type mode;
      logic [15:0]  baud_div;
      logic [15:0]  baud_cnt;
      logic [7:0]   hold_data;
      logic         hold_full;
      logic         hold_free;
      logic         busy;
      logic [11:0]  sh;
      logic [3:0]   left;
      logic         txd_sh;
      logic         txd;
      utb_brk_type  brk;
      logic [3:0]   cnt;
      logic         stop_req;
      logic         all_empty;
   } utb_state_type;

   localparam utb_state_type STATE_RST = '{
      waitreq: 1'b1, rdata: 32'h0, mode: MODE_RST, baud_div: BAUD_RST,
      baud_cnt: 16'h0, hold_data: 8'h0, hold_full: 1'b0, hold_free: 1'b1,
      busy: 1'b0, sh: 12'hfff, left: 4'h0, txd_sh: 1'b1, txd: 1'b1,
      brk: ST_IDLE, cnt: 4'h0, stop_req: 1'b0, all_empty: 1'b1};
endpackage
`default_nettype wire

// File: utb_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module utb_rx_model
#(
   parameter int D = 2
)
(
   input  wire logic clk,
   input  wire logic txd,
   input  wire logic par_en
);
   int         par_err = 0;
   logic [7:0] rxq[$];
   int         brk_cnt = 0;
   int         brk_low = 0;
   int         brk_idle = 0;
   logic [7:0] b;
   int         n;
   bit         seen = 0;
   // Samples on the falling edge, away from the line's update edge
   initial
   begin
      forever
      begin
         if (!seen)
            @(negedge clk);
         seen = 0;
         if (txd === 1'b0)
         begin
            repeat (D / 2) @(negedge clk);
            for (int i = 0; i < 8; i++)
            begin
               repeat (D) @(negedge clk);
               b[i] = txd;
            end
            if (par_en)
            begin
               repeat (D) @(negedge clk);
               if (txd !== ^b)
                  par_err++;
            end
            repeat (D) @(negedge clk);
            if (txd === 1'b1)
               rxq.push_back(b);
            else
            begin
               // Low stop bit: a break, measure its length and idle after
               brk_cnt++;
               n = 1 + D / 2 + (par_en ? 10 : 9) * D;
               while (txd === 1'b0 && n < 2000)
               begin
                  @(negedge clk);
                  n++;
               end
               brk_low = n - 1;
               n = 1;
               while (n < 400)
               begin
                  @(negedge clk);
                  if (txd !== 1'b1)
                     break;
                  n++;
               end
               brk_idle = n;
               seen = (txd === 1'b0);
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: utb_tx_break_tb.sv
`timescale 1ns/1ps
`default_nettype none
module utb_tx_break_tb;
   localparam int D = 2;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [7:0]  a_r = 8'h00;
   logic        rd_r = 1'b0;
   logic        wr_r = 1'b0;
   logic [31:0] wd_r = 32'h0;
   logic [3:0]  be_r = 4'hf;
   logic        par_r = 1'b0;
   wire  [31:0] avs_readdata;
   wire         avs_waitrequest;
   wire         txd;
   int          error_cnt = 0;
   int          n_compared = 0;
   logic [31:0] rd;
   logic [7:0]  v;
   logic [7:0]  expq[$];

   always #12.5 clk = ~clk;

   utb_tx_break dut
   (
      .clk             (clk),
      .reset           (reset),
      .avs_address     (a_r),
      .avs_read        (rd_r),
      .avs_write       (wr_r),
      .avs_writedata   (wd_r),
      .avs_byteenable  (be_r),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .txd             (txd)
   );

   utb_rx_model #(.D(D)) rx (.clk(clk), .txd(txd), .par_en(par_r));

   task conclude;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task chk_ge(input int got, input int lim);
      n_compared++;
      if (got < lim)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h min=%h", $time, got, lim);
      end
   endtask

   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      a_r  <= a;
      wd_r <= d;
      wr_r <= wr;
      rd_r <= !wr;
      for (i = 0; i < 50; i++)
      begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0)
            break;
      end
      if (i == 50)
      begin
         error_cnt++;
         conclude();
      end
      rd = avs_readdata;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
   endtask

   task wait_st(input logic [31:0] m, input logic [31:0] x);
      for (int i = 0; i < 300; i++)
      begin
         bus(1'b0, utb_pkg::CSR_OFF, 32'h0);
         if ((rd & m) === x)
            return;
      end
      error_cnt++;
      conclude();
   endtask

   task send;
      v = 8'($urandom);
      expq.push_back(v);
      wait_st(32'h2, 32'h2);
      bus(1'b1, utb_pkg::THR_OFF, {24'h0, v});
   endtask

   initial
   begin
      void'($urandom(8));
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      bus(1'b0, utb_pkg::CSR_OFF, 32'h0);
      chk(rd, 32'h0000_0202);
      bus(1'b0, utb_pkg::BAUD_OFF, 32'h0);
      chk(rd, 32'h0000_0010);
      bus(1'b0, 8'h3c, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, utb_pkg::CR_OFF, 32'h0000_0400);
      bus(1'b1, utb_pkg::BAUD_OFF, D);
      repeat (40) @(posedge clk);
      chk(txd, 1'b1);
      bus(1'b0, utb_pkg::CSR_OFF, 32'h0);
      chk(rd, 32'h0000_0202);
      $display("test reset and stray end done");
      repeat (3) send();
      wait_st(32'h202, 32'h202);
      send();
      wait_st(32'h2, 32'h2);
      bus(1'b1, utb_pkg::CR_OFF, 32'h0000_0200);
      bus(1'b0, utb_pkg::CSR_OFF, 32'h0);
      chk(rd & 32'h2, 32'h0);
      bus(1'b1, utb_pkg::THR_OFF, 32'h0000_00a5);
      wait_st(32'h202, 32'h002);
      chk(txd, 1'b0);
      bus(1'b1, utb_pkg::CR_OFF, 32'h0000_0200);
      bus(1'b1, utb_pkg::CR_OFF, 32'h0000_0400);
      bus(1'b0, utb_pkg::CSR_OFF, 32'h0);
      chk(rd & 32'h2, 32'h0);
      wait_st(32'h202, 32'h202);
      send();
      wait_st(32'h202, 32'h202);
      repeat (8 * D) @(posedge clk);
      chk_ge(rx.brk_low, 10 * D);
      chk_ge(rx.brk_idle, 12 * D);
      chk(rx.brk_cnt, 1);
      $display("test break sequence done");
      be_r <= 4'h0;
      bus(1'b1, utb_pkg::MODE_OFF, 32'h1);
      be_r <= 4'hf;
      bus(1'b0, utb_pkg::MODE_OFF, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, utb_pkg::MODE_OFF, 32'h1);
      bus(1'b0, utb_pkg::MODE_OFF, 32'h0);
      chk(rd, 32'h1);
      par_r <= 1'b1;
      send();
      bus(1'b1, utb_pkg::MODE_OFF, 32'h3);
      bus(1'b0, utb_pkg::MODE_OFF, 32'h0);
      chk(rd, 32'h3);
      send();
      wait_st(32'h202, 32'h202);
      repeat (8 * D) @(posedge clk);
      chk(rx.par_err, 0);
      chk(rx.rxq.size(), expq.size());
      while (expq.size() > 0 && rx.rxq.size() > 0)
         chk(rx.rxq.pop_front(), expq.pop_front());
      $display("test mode and parity done");
      conclude();
   end
endmodule
`default_nettype wire
